// ### logic/mas_pkg.sv
// package with the alert bank register map, field masks and state type
package mas_pkg;
  localparam int NGRP = 6;
  localparam int GRP_VOLT = 0;
  localparam int GRP_TMP = 1;
  localparam int GRP_CUR = 2;
  localparam int GRP_SUP = 3;
  localparam int GRP_SHN = 4;
  localparam int GRP_INT = 5;
  localparam logic [7:0] OFS_SUMMARY = 8'h10;
  // offsets of groups 5..0
  localparam logic [NGRP-1:0][7:0] GRP_OFS = {8'h1A, 8'h19, 8'h18, 8'h15, 8'h14, 8'h12};
  localparam logic [NGRP-1:0][15:0] GRP_HI_MASK =
    {16'h0F00, 16'h0F00, 16'hFF00, 16'h0F00, 16'h0700, 16'h0F00};
  localparam logic [NGRP-1:0][15:0] GRP_LO_MASK =
    {16'h0001, 16'h000F, 16'h00FF, 16'h000F, 16'h0007, 16'h000F};
  // summary bit positions fed by each group's high and low halves
  localparam logic [NGRP-1:0][3:0] SUM_HI_BIT = {4'hD, 4'hF, 4'hE, 4'hB, 4'hA, 4'h8};
  localparam logic [NGRP-1:0][3:0] SUM_LO_BIT = {4'hC, 4'h7, 4'h6, 4'h3, 4'h2, 4'h0};
  localparam logic [15:0] SUM_MASK = 16'hFDCD;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam int HI_LSB = 8;
  typedef struct packed {
    logic [NGRP-1:0][15:0] grp;
    logic [15:0] rdata;
  } mas_state_t;
endpackage

// ### logic/mas_alert_bank.sv
// sticky alert status bank with group summary and write-one-to-clear access
`timescale 1ns/1ns
`default_nettype none
module mas_alert_bank (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] uncommitted_voltage_input_high_alert,
  input wire logic [3:0] uncommitted_voltage_input_low_alert,
  input wire logic internal_temperature_channel_high_alert,
  input wire logic internal_temperature_channel_low_alert,
  input wire logic external_diode_channel_a_high_alert,
  input wire logic external_diode_channel_a_low_alert,
  input wire logic external_diode_channel_b_high_alert,
  input wire logic external_diode_channel_b_low_alert,
  input wire logic [3:0] current_sense_high_alert,
  input wire logic [3:0] current_sense_low_alert,
  input wire logic [3:0] bipolar_dac_output_monitor_high_alert,
  input wire logic [3:0] bipolar_dac_output_monitor_low_alert,
  input wire logic analog_negative_supply_high_alert,
  input wire logic analog_negative_supply_low_alert,
  input wire logic bipolar_dac_supply_high_alert,
  input wire logic bipolar_dac_supply_low_alert,
  input wire logic unipolar_dac_supply_high_alert,
  input wire logic unipolar_dac_supply_low_alert,
  input wire logic analog_positive_supply_high_alert,
  input wire logic analog_positive_supply_low_alert,
  input wire logic [3:0] shunt_high_side_monitor_high_alert,
  input wire logic [3:0] shunt_high_side_monitor_low_alert,
  input wire logic [3:0] integrator_limit_flag,
  input wire logic supply_alarm
);
  mas_pkg::mas_state_t state_q;
  mas_pkg::mas_state_t state_d;
  logic [mas_pkg::NGRP-1:0][15:0] set_vec;
  logic [mas_pkg::NGRP-1:0][15:0] clr_vec;
  logic [15:0] summary;
  logic [15:0] sum_model;

  // place each alert input at its register bit
  always_comb begin
    set_vec[mas_pkg::GRP_VOLT] = {4'h0, uncommitted_voltage_input_high_alert,
                                 4'h0, uncommitted_voltage_input_low_alert};
    set_vec[mas_pkg::GRP_TMP] = {5'h00, external_diode_channel_b_high_alert,
                                 external_diode_channel_a_high_alert,
                                 internal_temperature_channel_high_alert,
                                 5'h00, external_diode_channel_b_low_alert,
                                 external_diode_channel_a_low_alert,
                                 internal_temperature_channel_low_alert};
    set_vec[mas_pkg::GRP_CUR] = {4'h0, current_sense_high_alert,
                                 4'h0, current_sense_low_alert};
    set_vec[mas_pkg::GRP_SUP][15:8] = {bipolar_dac_output_monitor_high_alert,
                                       analog_negative_supply_high_alert,
                                       bipolar_dac_supply_high_alert,
                                       unipolar_dac_supply_high_alert,
                                       analog_positive_supply_high_alert};
    set_vec[mas_pkg::GRP_SUP][7:0] = {bipolar_dac_output_monitor_low_alert,
                                      analog_negative_supply_low_alert,
                                      bipolar_dac_supply_low_alert,
                                      unipolar_dac_supply_low_alert,
                                      analog_positive_supply_low_alert};
    set_vec[mas_pkg::GRP_SHN] = {4'h0, shunt_high_side_monitor_high_alert,
                                 4'h0, shunt_high_side_monitor_low_alert};
    set_vec[mas_pkg::GRP_INT] = {4'h0, integrator_limit_flag,
                                 7'h00, supply_alarm};
  end

  // summary is pure OR of the stored bits, so it can never disagree with its groups
  always_comb begin
    summary = mas_pkg::RESET_VAL;
    for (int g = 0; g < mas_pkg::NGRP; g++) begin
      summary[mas_pkg::SUM_HI_BIT[g]] = |(state_q.grp[g] & mas_pkg::GRP_HI_MASK[g]);
      summary[mas_pkg::SUM_LO_BIT[g]] = |(state_q.grp[g] & mas_pkg::GRP_LO_MASK[g]);
    end
    summary = summary & mas_pkg::SUM_MASK;
  end

  always_comb begin
    for (int g = 0; g < mas_pkg::NGRP; g++) begin
      clr_vec[g] = 16'h0000;
      if (reg_wr && reg_addr == mas_pkg::GRP_OFS[g]) begin
        clr_vec[g] = reg_wdata;
      end
      if (reg_wr && reg_addr == mas_pkg::OFS_SUMMARY) begin
        // a summary write clears only the half of the group behind that bit
        if (reg_wdata[mas_pkg::SUM_HI_BIT[g]]) begin
          clr_vec[g] = clr_vec[g] | mas_pkg::GRP_HI_MASK[g];
        end
        if (reg_wdata[mas_pkg::SUM_LO_BIT[g]]) begin
          clr_vec[g] = clr_vec[g] | mas_pkg::GRP_LO_MASK[g];
        end
      end
    end
  end

  always_comb begin
    state_d = state_q;
    for (int g = 0; g < mas_pkg::NGRP; g++) begin
      // set applied after clear so an alert in the clearing cycle is kept
      state_d.grp[g] = ((state_q.grp[g] & ~clr_vec[g]) | set_vec[g]) &
                       (mas_pkg::GRP_HI_MASK[g] | mas_pkg::GRP_LO_MASK[g]);
    end
    if (reg_rd) begin
      state_d.rdata = mas_pkg::RESET_VAL;
      if (reg_addr == mas_pkg::OFS_SUMMARY) begin
        state_d.rdata = summary;
      end
      for (int g = 0; g < mas_pkg::NGRP; g++) begin
        if (reg_addr == mas_pkg::GRP_OFS[g]) begin
          state_d.rdata = state_q.grp[g];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata = state_q.rdata;

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_volt_set_sticky: assert property (
    uncommitted_voltage_input_high_alert[0] |=> state_q.grp[mas_pkg::GRP_VOLT][mas_pkg::HI_LSB])
    else $error("voltage high alert not captured");
  a_volt_hold_sticky: assert property (
    state_q.grp[mas_pkg::GRP_VOLT][0] && !(reg_wr && reg_addr == mas_pkg::OFS_SUMMARY)
    && !(reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_VOLT])
    |=> state_q.grp[mas_pkg::GRP_VOLT][0])
    else $error("voltage low alert dropped without clear");
  a_shunt_w1c_clear: assert property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SHN] && reg_wdata[0]
    && !shunt_high_side_monitor_low_alert[0] |=> !state_q.grp[mas_pkg::GRP_SHN][0])
    else $error("shunt alert not cleared by write one");
  a_sup_set_wins: assert property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SUP] && reg_wdata[15]
    && bipolar_dac_output_monitor_high_alert[3] |=> state_q.grp[mas_pkg::GRP_SUP][15])
    else $error("set lost to clear");
  a_sum_or_group: assert property (
    summary == sum_model)
    else $error("summary differs from group contents");
  a_sum_clears_group: assert property (
    reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata[mas_pkg::SUM_LO_BIT[mas_pkg::GRP_TMP]]
    && !internal_temperature_channel_low_alert && !external_diode_channel_a_low_alert
    && !external_diode_channel_b_low_alert
    |=> state_q.grp[mas_pkg::GRP_TMP][2:0] == 3'h0)
    else $error("summary write left temperature lows");
  a_reserved_zero: assert property (
    (state_q.grp[mas_pkg::GRP_INT] & 16'hF0FE) == 16'h0000
    && (state_q.grp[mas_pkg::GRP_TMP] & 16'hF8F8) == 16'h0000)
    else $error("reserved bit set");
  a_int_alarm_read: assert property (
    reg_rd && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_INT]
    |=> reg_rdata == $past(state_q.grp[mas_pkg::GRP_INT]))
    else $error("integrator register read wrong");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 8'h11 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // summary rebuilt bit by bit, independent of the position tables
  always_comb begin
    sum_model = {|(state_q.grp[mas_pkg::GRP_SHN] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_SHN]),
                 |(state_q.grp[mas_pkg::GRP_SUP] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_SUP]),
                 |(state_q.grp[mas_pkg::GRP_INT] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_INT]),
                 |(state_q.grp[mas_pkg::GRP_INT] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_INT]),
                 |(state_q.grp[mas_pkg::GRP_CUR] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_CUR]),
                 |(state_q.grp[mas_pkg::GRP_TMP] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_TMP]),
                 1'h0,
                 |(state_q.grp[mas_pkg::GRP_VOLT] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_VOLT]),
                 |(state_q.grp[mas_pkg::GRP_SHN] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_SHN]),
                 |(state_q.grp[mas_pkg::GRP_SUP] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_SUP]),
                 2'h0,
                 |(state_q.grp[mas_pkg::GRP_CUR] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_CUR]),
                 |(state_q.grp[mas_pkg::GRP_TMP] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_TMP]),
                 1'h0,
                 |(state_q.grp[mas_pkg::GRP_VOLT] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_VOLT])};
  end

  a_sum_read_view: assert property (
    reg_rd && reg_addr == mas_pkg::OFS_SUMMARY |=> reg_rdata == $past(sum_model))
    else $error("summary read wrong");

  // each read returns the word stored at the read edge
  a_volt_read_word: assert property (
    reg_rd && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_VOLT]
    |=> reg_rdata == $past(state_q.grp[mas_pkg::GRP_VOLT]))
    else $error("voltage register read wrong");
  a_tmp_read_word: assert property (
    reg_rd && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_TMP]
    |=> reg_rdata == $past(state_q.grp[mas_pkg::GRP_TMP]))
    else $error("temperature register read wrong");
  a_cur_read_word: assert property (
    reg_rd && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_CUR]
    |=> reg_rdata == $past(state_q.grp[mas_pkg::GRP_CUR]))
    else $error("current register read wrong");
  a_sup_read_word: assert property (
    reg_rd && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SUP]
    |=> reg_rdata == $past(state_q.grp[mas_pkg::GRP_SUP]))
    else $error("supply register read wrong");
  a_shunt_read_word: assert property (
    reg_rd && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SHN]
    |=> reg_rdata == $past(state_q.grp[mas_pkg::GRP_SHN]))
    else $error("shunt register read wrong");

  // a written one clears its bit unless an alert lands on the same edge
  a_volt_w1c_clear: assert property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_VOLT]
    |=> (state_q.grp[mas_pkg::GRP_VOLT] & $past(reg_wdata)
         & ~$past(set_vec[mas_pkg::GRP_VOLT])) == 16'h0000)
    else $error("voltage alert not cleared by write one");
  a_tmp_w1c_clear: assert property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_TMP]
    |=> (state_q.grp[mas_pkg::GRP_TMP] & $past(reg_wdata)
         & ~$past(set_vec[mas_pkg::GRP_TMP])) == 16'h0000)
    else $error("temperature alert not cleared by write one");
  a_cur_w1c_clear: assert property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_CUR]
    |=> (state_q.grp[mas_pkg::GRP_CUR] & $past(reg_wdata)
         & ~$past(set_vec[mas_pkg::GRP_CUR])) == 16'h0000)
    else $error("current alert not cleared by write one");
  a_sup_w1c_clear: assert property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SUP]
    |=> (state_q.grp[mas_pkg::GRP_SUP] & $past(reg_wdata)
         & ~$past(set_vec[mas_pkg::GRP_SUP])) == 16'h0000)
    else $error("supply alert not cleared by write one");
  a_int_w1c_clear: assert property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_INT]
    |=> (state_q.grp[mas_pkg::GRP_INT] & $past(reg_wdata)
         & ~$past(set_vec[mas_pkg::GRP_INT])) == 16'h0000)
    else $error("integrator flag not cleared by write one");

  // bits only fall through a clearing write
  a_tmp_hold_sticky: assert property (
    !(reg_wr && (reg_addr == mas_pkg::OFS_SUMMARY
                 || reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_TMP]))
    |=> (state_q.grp[mas_pkg::GRP_TMP] & $past(state_q.grp[mas_pkg::GRP_TMP]))
        == $past(state_q.grp[mas_pkg::GRP_TMP]))
    else $error("temperature alert dropped without clear");
  a_cur_hold_sticky: assert property (
    !(reg_wr && (reg_addr == mas_pkg::OFS_SUMMARY
                 || reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_CUR]))
    |=> (state_q.grp[mas_pkg::GRP_CUR] & $past(state_q.grp[mas_pkg::GRP_CUR]))
        == $past(state_q.grp[mas_pkg::GRP_CUR]))
    else $error("current alert dropped without clear");
  a_sup_hold_sticky: assert property (
    !(reg_wr && (reg_addr == mas_pkg::OFS_SUMMARY
                 || reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SUP]))
    |=> (state_q.grp[mas_pkg::GRP_SUP] & $past(state_q.grp[mas_pkg::GRP_SUP]))
        == $past(state_q.grp[mas_pkg::GRP_SUP]))
    else $error("supply alert dropped without clear");
  a_shunt_hold_sticky: assert property (
    !(reg_wr && (reg_addr == mas_pkg::OFS_SUMMARY
                 || reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SHN]))
    |=> (state_q.grp[mas_pkg::GRP_SHN] & $past(state_q.grp[mas_pkg::GRP_SHN]))
        == $past(state_q.grp[mas_pkg::GRP_SHN]))
    else $error("shunt alert dropped without clear");
  a_int_hold_sticky: assert property (
    !(reg_wr && (reg_addr == mas_pkg::OFS_SUMMARY
                 || reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_INT]))
    |=> (state_q.grp[mas_pkg::GRP_INT] & $past(state_q.grp[mas_pkg::GRP_INT]))
        == $past(state_q.grp[mas_pkg::GRP_INT]))
    else $error("integrator flag dropped without clear");

  // a summary write clears the group half behind each bit
  a_sum_clears_shunt: assert property (
    reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata[15]
    |=> (state_q.grp[mas_pkg::GRP_SHN] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_SHN]
         & ~$past(set_vec[mas_pkg::GRP_SHN])) == 16'h0000)
    else $error("summary write left shunt highs");
  a_sum_clears_supply: assert property (
    reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata[6]
    |=> (state_q.grp[mas_pkg::GRP_SUP] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_SUP]
         & ~$past(set_vec[mas_pkg::GRP_SUP])) == 16'h0000)
    else $error("summary write left supply lows");
  a_sum_clears_integrator: assert property (
    reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata[13]
    |=> (state_q.grp[mas_pkg::GRP_INT] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_INT]
         & ~$past(set_vec[mas_pkg::GRP_INT])) == 16'h0000)
    else $error("summary write left integrator flags");
  a_sum_clears_current: assert property (
    reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata[11]
    |=> (state_q.grp[mas_pkg::GRP_CUR] & mas_pkg::GRP_HI_MASK[mas_pkg::GRP_CUR]
         & ~$past(set_vec[mas_pkg::GRP_CUR])) == 16'h0000)
    else $error("summary write left current highs");
  a_sum_clears_voltage: assert property (
    reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata[0]
    |=> (state_q.grp[mas_pkg::GRP_VOLT] & mas_pkg::GRP_LO_MASK[mas_pkg::GRP_VOLT]
         & ~$past(set_vec[mas_pkg::GRP_VOLT])) == 16'h0000)
    else $error("summary write left voltage lows");

  c_alert_then_clear: cover property (
    supply_alarm ##1 (reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata[12]));
  c_set_and_clear: cover property (
    reg_wr && reg_addr == mas_pkg::GRP_OFS[mas_pkg::GRP_SHN] && reg_wdata[8]
    && shunt_high_side_monitor_high_alert[0]);
  c_summary_read: cover property (
    reg_rd && reg_addr == mas_pkg::OFS_SUMMARY && summary != 16'h0000);
  c_all_groups_set: cover property (
    summary == mas_pkg::SUM_MASK);
  c_summary_clear_all: cover property (
    reg_wr && reg_addr == mas_pkg::OFS_SUMMARY && reg_wdata == 16'hFFFF);
endmodule // mas_alert_bank
`default_nettype wire

// ### dv/mas_alert_bank_tb.sv
// self-checking bench for the sticky alert status bank
`timescale 1ns/1ns
`default_nettype none
module mas_alert_bank_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  // alert stimulus laid out in register bit order, one word per group
  logic [5:0][15:0] st = '0;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  // groups: voltage, temperature, current, supply/bipolar, shunt, integrator
  localparam logic [5:0][7:0] OFS = {8'h1A, 8'h19, 8'h18, 8'h15, 8'h14, 8'h12};
  localparam logic [5:0][15:0] MSK = {16'h0F01, 16'h0F0F, 16'hFFFF, 16'h0F0F, 16'h0707, 16'h0F0F};
  localparam logic [5:0][3:0] SHI = {4'hD, 4'hF, 4'hE, 4'hB, 4'hA, 4'h8};
  localparam logic [5:0][3:0] SLO = {4'hC, 4'h7, 4'h6, 4'h3, 4'h2, 4'h0};
  mas_alert_bank dut (
    .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .uncommitted_voltage_input_high_alert(st[0][11:8]),
    .uncommitted_voltage_input_low_alert(st[0][3:0]),
    .internal_temperature_channel_high_alert(st[1][8]),
    .internal_temperature_channel_low_alert(st[1][0]),
    .external_diode_channel_a_high_alert(st[1][9]), .external_diode_channel_a_low_alert(st[1][1]),
    .external_diode_channel_b_high_alert(st[1][10]), .external_diode_channel_b_low_alert(st[1][2]),
    .current_sense_high_alert(st[2][11:8]), .current_sense_low_alert(st[2][3:0]),
    .bipolar_dac_output_monitor_high_alert(st[3][15:12]),
    .bipolar_dac_output_monitor_low_alert(st[3][7:4]),
    .analog_negative_supply_high_alert(st[3][11]), .analog_negative_supply_low_alert(st[3][3]),
    .bipolar_dac_supply_high_alert(st[3][10]), .bipolar_dac_supply_low_alert(st[3][2]),
    .unipolar_dac_supply_high_alert(st[3][9]), .unipolar_dac_supply_low_alert(st[3][1]),
    .analog_positive_supply_high_alert(st[3][8]), .analog_positive_supply_low_alert(st[3][0]),
    .shunt_high_side_monitor_high_alert(st[4][11:8]),
    .shunt_high_side_monitor_low_alert(st[4][3:0]),
    .integrator_limit_flag(st[5][11:8]), .supply_alarm(st[5][0])
  );
  always #5 clk = ~clk;
  function automatic logic [15:0] sum_of(input int g, input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    if (|(v & MSK[g] & 16'hFF00)) r[SHI[g]] = 1'b1;
    if (|(v & MSK[g] & 16'h00FF)) r[SLO[g]] = 1'b1;
    return r;
  endfunction
  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // sampled two edges after the strobe; read data holds until the next read
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 chk(reg_rdata, exp);
  endtask
  task automatic pulse(input int g, input logic [15:0] v);
    @(posedge clk);
    st[g] <= v;
    @(posedge clk);
    st[g] <= 16'h0000;
  endtask
  // alert and clearing write land on the same edge
  task automatic setclr(input int g, input logic [15:0] v, input logic [7:0] a,
                        input logic [15:0] d);
    @(posedge clk);
    st[g] <= v;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    st[g] <= 16'h0000;
    reg_wr <= 1'b0;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: run did not finish", $time);
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int g = 0; g < 6; g++) rd(OFS[g], 16'h0000);
    rd(8'h10, 16'h0000);
    rd(8'h11, 16'h0000);
    $display("test reset done");
    for (int g = 0; g < 6; g++) begin
      for (int b = 0; b < 16; b++) begin
        pulse(g, 16'h0001 << b);
        rd(OFS[g], MSK[g] & (16'h0001 << b));
        rd(8'h10, sum_of(g, 16'h0001 << b));
        wr(OFS[g], 16'h0001 << b);
        rd(OFS[g], 16'h0000);
      end
    end
    $display("test bit map done");
    @(posedge clk);
    st <= {6{16'hFFFF}};
    @(posedge clk);
    st <= '0;
    rd(8'h10, 16'hFDCD);
    wr(8'h18, 16'h0000);
    rd(8'h18, 16'hFFFF);
    wr(8'h19, 16'hF0F0);
    rd(8'h19, 16'h0F0F);
    wr(8'h10, 16'h0100);
    rd(8'h12, 16'h000F);
    wr(8'h10, 16'h1000);
    rd(8'h1A, 16'h0F00);
    wr(8'h11, 16'hFFFF);
    rd(8'h10, 16'hECCD);
    wr(8'h10, 16'hFFFF);
    for (int g = 0; g < 6; g++) rd(OFS[g], 16'h0000);
    $display("test summary clear done");
    // alert arriving in the clearing cycle must survive
    setclr(2, 16'h0004, 8'h15, 16'h0004);
    rd(8'h15, 16'h0004);
    @(posedge clk);
    st[2] <= 16'h0400;
    wr(8'h15, 16'h0404);
    rd(8'h15, 16'h0400);
    @(posedge clk);
    st[2] <= 16'h0000;
    wr(8'h15, 16'h0400);
    rd(8'h15, 16'h0000);
    setclr(3, 16'h8000, 8'h18, 16'h8000);
    rd(8'h18, 16'h8000);
    setclr(4, 16'h0100, 8'h19, 16'h0100);
    rd(8'h19, 16'h0100);
    setclr(5, 16'h0001, 8'h10, 16'h1000);
    rd(8'h1A, 16'h0001);
    rd(8'h10, 16'hD000);
    $display("test sticky done");
    // reset in mid-run with alerts stored and read data standing
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(reg_rdata, 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    for (int g = 0; g < 6; g++) rd(OFS[g], 16'h0000);
    rd(8'h10, 16'h0000);
    $display("test mid reset done");
    test_done();
  end
endmodule // mas_alert_bank_tb
`default_nettype wire
